// ### core/cef_event_logic.sv
// Purpose: Event flag capture, mask register and host alert pulse
// Assumes: Status signals are asynchronous levels; register port is local
// Notes: Flags clear on read; a new event in the read cycle stays set
`timescale 1ns/1ps
module cef_event_logic (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Register port
    input wire logic reg_rd,
    input wire logic reg_wr,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_reset_cmd,
    input wire logic watchdog_expired,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    // Regulation and status inputs
    input wire logic input_current_regulation,
    input wire logic input_voltage_regulation,
    input wire logic die_thermal_regulation,
    input wire logic watchdog_expiry_status,
    input wire logic [2:0] charge_state_code,
    input wire logic power_good,
    input wire logic [2:0] input_source_code,
    input wire logic [2:0] battery_temp_zone_code,
    input wire logic [1:0] current_optimizer_state,
    input wire logic minimum_system_regulation,
    // Fault inputs
    input wire logic input_overvoltage,
    input wire logic thermal_shutdown,
    input wire logic battery_overvoltage,
    input wire logic safety_timer_expired,
    input wire logic reverse_output_fault,
    // Conversion engine
    input wire logic conversion_rate,
    input wire logic conversion_done,
    // Host alert
    output logic host_alert
);
    import cef_pkg::*;

    // Width of the gathered source word: sixteen fields, 23 bits
    localparam int SW = 23;

    typedef struct packed {
        logic [SW-1:0] prev;
        logic primed;
        logic [7:0] flags_a;
        logic [7:0] flags_b;
        logic [7:0] fault;
        logic [7:0] mask_a;
        logic [7:0] rdata;
        logic rvalid;
        logic alert;
    } cef_state_t;

    cef_state_t st_reg;
    cef_state_t st_next;

    logic [SW-1:0] raw;
    logic [SW-1:0] cur;

    // Rise detector shared by the single-bit sources except power good and system floor; change detector for 3-bit codes
    function automatic logic rise(input logic now, input logic was);
        return now & ~was;
    endfunction : rise

    function automatic logic changed(input logic [2:0] now,
                                     input logic [2:0] was);
        return |(now ^ was);
    endfunction : changed

    // Gather every asynchronous source into one synchronised word
    assign raw = {conversion_done, reverse_output_fault,
                  safety_timer_expired, battery_overvoltage,
                  thermal_shutdown, input_overvoltage,
                  minimum_system_regulation, current_optimizer_state,
                  battery_temp_zone_code, input_source_code, power_good,
                  charge_state_code, watchdog_expiry_status,
                  die_thermal_regulation, input_voltage_regulation,
                  input_current_regulation};

    cef_sync #(
        .W(SW)
    ) u_sync (
        .clk(clk),
        .rstn(rstn),
        .d(raw),
        .q(cur)
    );

    // Synchronised fields, bit order matches the concatenation above
    logic s_cur_reg, s_volt_reg, s_die_reg, s_wdog;
    logic [2:0] s_charge, s_source, s_zone;
    logic s_pgood, s_sysfloor, s_in_ovp, s_thermal_shutdown, s_bat_ovp;
    logic s_timer, s_revout, s_done;
    logic [1:0] s_optim;
    logic p_cur_reg, p_volt_reg, p_die_reg, p_wdog;
    logic [2:0] p_charge, p_source, p_zone;
    logic p_pgood, p_sysfloor, p_in_ovp, p_thermal_shutdown, p_bat_ovp;
    logic p_timer, p_revout, p_done;
    logic [1:0] p_optim;

    assign {s_done, s_revout, s_timer, s_bat_ovp, s_thermal_shutdown, s_in_ovp,
            s_sysfloor, s_optim, s_zone, s_source, s_pgood, s_charge,
            s_wdog, s_die_reg, s_volt_reg, s_cur_reg} = cur;
    assign {p_done, p_revout, p_timer, p_bat_ovp, p_thermal_shutdown, p_in_ovp,
            p_sysfloor, p_optim, p_zone, p_source, p_pgood, p_charge,
            p_wdog, p_die_reg, p_volt_reg, p_cur_reg} = st_reg.prev;

    logic [7:0] ev_a, ev_b, ev_f, unmasked_a;
    logic done_ev;

    // Edge and change detection; suppressed until a first sample exists
    always_comb begin
        ev_a = 8'h00;
        ev_b = 8'h00;
        ev_f = 8'h00;
        done_ev = 1'b0;
        if (st_reg.primed) begin
            ev_a[CEF_BIT_CUR_REG] = rise(s_cur_reg, p_cur_reg);
            ev_a[CEF_BIT_VOLT_REG] = rise(s_volt_reg, p_volt_reg);
            ev_a[CEF_BIT_DIE_REG] = rise(s_die_reg, p_die_reg);
            ev_a[CEF_BIT_WDOG] = rise(s_wdog, p_wdog);
            ev_a[CEF_BIT_CHARGE] = changed(s_charge, p_charge);
            ev_b[CEF_BIT_PGOOD] = s_pgood ^ p_pgood;
            ev_b[CEF_BIT_SOURCE] = changed(s_source, p_source);
            ev_b[CEF_BIT_ZONE] = changed(s_zone, p_zone);
            ev_b[CEF_BIT_OPTIM] = |(s_optim ^ p_optim);
            ev_b[CEF_BIT_SYSFLOOR] = s_sysfloor ^ p_sysfloor;
            ev_f[CEF_BIT_IN_OVP] = rise(s_in_ovp, p_in_ovp);
            ev_f[CEF_BIT_TSHUTDN] = rise(s_thermal_shutdown, p_thermal_shutdown);
            ev_f[CEF_BIT_BAT_OVP] = rise(s_bat_ovp, p_bat_ovp);
            ev_f[CEF_BIT_TIMER] = rise(s_timer, p_timer);
            ev_f[CEF_BIT_REVOUT] = rise(s_revout, p_revout);
            // Completion only counts in single-conversion mode
            done_ev = rise(s_done, p_done)
                      & (conversion_rate == CEF_RATE_SINGLE);
        end
        // A mask bit of one suppresses the alert for that event
        unmasked_a = 8'h00;
        unmasked_a[CEF_BIT_CONV_DONE] = done_ev
            & ~st_reg.mask_a[CEF_BIT_CONV_DONE];
        unmasked_a[CEF_BIT_CUR_REG] = ev_a[CEF_BIT_CUR_REG]
            & ~st_reg.mask_a[CEF_BIT_CUR_REG];
        unmasked_a[CEF_BIT_VOLT_REG] = ev_a[CEF_BIT_VOLT_REG]
            & ~st_reg.mask_a[CEF_BIT_VOLT_REG];
        unmasked_a[CEF_BIT_DIE_REG] = ev_a[CEF_BIT_DIE_REG]
            & ~st_reg.mask_a[CEF_BIT_DIE_REG];
        unmasked_a[CEF_BIT_WDOG] = ev_a[CEF_BIT_WDOG]
            & ~st_reg.mask_a[CEF_BIT_WDOG];
        unmasked_a[CEF_BIT_CHARGE] = ev_a[CEF_BIT_CHARGE]
            & ~st_reg.mask_a[CEF_BIT_CHARGE];
    end

    logic rd_a, rd_b, rd_f;
    assign rd_a = reg_rd && (reg_addr == CEF_FLAGS_A_ADDR);
    assign rd_b = reg_rd && (reg_addr == CEF_FLAGS_B_ADDR);
    assign rd_f = reg_rd && (reg_addr == CEF_FAULT_ADDR);

    // Next-state: read clears, but a same-cycle event wins over the clear
    always_comb begin
        st_next = st_reg;
        st_next.prev = cur;
        st_next.primed = 1'b1;
        st_next.flags_a = (rd_a ? 8'h00 : st_reg.flags_a) | ev_a;
        st_next.flags_b = (rd_b ? 8'h00 : st_reg.flags_b) | ev_b;
        st_next.fault = (rd_f ? 8'h00 : st_reg.fault) | ev_f;
        st_next.flags_a = st_next.flags_a & CEF_FLAGS_A_USED;
        st_next.flags_b = st_next.flags_b & CEF_FLAGS_B_USED;
        st_next.fault = st_next.fault & CEF_FAULT_USED;
        // Only writable mask fields take data
        if (reg_wr && (reg_addr == CEF_MASK_A_ADDR)) begin
            st_next.mask_a = reg_wdata & CEF_MASK_A_USED;
        end
        // Read data returns the value before any clear
        st_next.rvalid = reg_rd;
        st_next.rdata = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                CEF_FLAGS_A_ADDR: st_next.rdata = st_reg.flags_a;
                CEF_FLAGS_B_ADDR: st_next.rdata = st_reg.flags_b;
                CEF_FAULT_ADDR: st_next.rdata = st_reg.fault;
                CEF_MASK_A_ADDR: st_next.rdata = st_reg.mask_a;
                default: st_next.rdata = 8'h00;
            endcase
        end
        // Second mask and fault mask live elsewhere, so those events
        // alert unconditionally here; one-cycle pulse per event cycle
        st_next.alert = (|unmasked_a) | (|ev_b) | (|ev_f);
        // Register reset command clears everything it owns; the
        // watchdog input is deliberately not used here
        if (reg_reset_cmd) begin
            st_next.flags_a = CEF_RESET_VAL;
            st_next.flags_b = CEF_RESET_VAL;
            st_next.fault = CEF_RESET_VAL;
            st_next.mask_a = CEF_RESET_VAL;
            st_next.alert = 1'b0;
        end
    end

    // Unused watchdog expiry is kept as a port to document immunity
    logic unused_wdog;
    assign unused_wdog = watchdog_expired;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign reg_rdata = st_reg.rdata;
    assign reg_rvalid = st_reg.rvalid;
    assign host_alert = st_reg.alert;
endmodule : cef_event_logic

// ### core/cef_pkg.sv
// Purpose: Constants for the charger event flag and mask logic
// Assumes: Registers are reached through a simple internal register port
// Notes: Operation
// Operation
// - Current regulation rising edge sets flag bit 6
// - Voltage regulation rising edge sets flag bit 5
// - Die thermal regulation rise sets bit 4
// - Watchdog expiry status rise sets bit 3
// - Charge state code change sets bit 0
// - Power good toggle sets flag b bit 7
// - Input source code change sets bit 4
// - Battery zone code change sets bit 2
// - Optimizer state change sets bit 1
// - System floor entry or exit sets bit 0
// - Input overvoltage entry sets fault bit 7
// - Thermal shutdown entry sets fault bit 6
// - Battery overvoltage entry sets fault bit 5
// - Safety timer expiry rise sets bit 4
// - Reverse output fault sets fault bit 0
// - Reset and reset command clear; watchdog doesn't
// - Reserved bits read only, read zero
// - Mask bit 7 gates one-shot conversion done
// - Mask bit 6 gates current regulation pulse
// - Mask bit 5 gates voltage regulation pulse
// - Mask bit 4 gates die thermal pulse
// - Mask bit 3 gates watchdog pulse
// - Mask bit 0 gates charge change pulse
// - Rate 0 continuous, 1 single conversion
package cef_pkg;
    // Register offsets
    localparam logic [7:0] CEF_FLAGS_A_ADDR = 8'h0f;
    localparam logic [7:0] CEF_FLAGS_B_ADDR = 8'h10;
    localparam logic [7:0] CEF_FAULT_ADDR = 8'h11;
    localparam logic [7:0] CEF_MASK_A_ADDR = 8'h12;
    // Reset value of all four registers
    localparam logic [7:0] CEF_RESET_VAL = 8'h00;
    // Implemented bits of each register
    localparam logic [7:0] CEF_FLAGS_A_USED = 8'h79;
    localparam logic [7:0] CEF_FLAGS_B_USED = 8'h97;
    localparam logic [7:0] CEF_FAULT_USED = 8'hf1;
    localparam logic [7:0] CEF_MASK_A_USED = 8'hf9;
    // Field positions, flags a and mask a
    localparam int CEF_BIT_CONV_DONE = 7;
    localparam int CEF_BIT_CUR_REG = 6;
    localparam int CEF_BIT_VOLT_REG = 5;
    localparam int CEF_BIT_DIE_REG = 4;
    localparam int CEF_BIT_WDOG = 3;
    localparam int CEF_BIT_CHARGE = 0;
    // Field positions, flags b
    localparam int CEF_BIT_PGOOD = 7;
    localparam int CEF_BIT_SOURCE = 4;
    localparam int CEF_BIT_ZONE = 2;
    localparam int CEF_BIT_OPTIM = 1;
    localparam int CEF_BIT_SYSFLOOR = 0;
    // Field positions, fault flags
    localparam int CEF_BIT_IN_OVP = 7;
    localparam int CEF_BIT_TSHUTDN = 6;
    localparam int CEF_BIT_BAT_OVP = 5;
    localparam int CEF_BIT_TIMER = 4;
    localparam int CEF_BIT_REVOUT = 0;
    // Conversion rate encoding
    localparam logic CEF_RATE_SINGLE = 1'b1;
    // Alert pulse width in cycles
    localparam int CEF_ALERT_CYCLES = 1;
endpackage : cef_pkg

// ### core/cef_sync.sv
// Purpose: Two-stage synchroniser for a bus of levels
// Assumes: Inputs come from outside the clock domain
// Notes: First stage is read only by the second
`timescale 1ns/1ps
module cef_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } cef_sync_t;

    cef_sync_t st_reg;
    cef_sync_t st_next;

    // Shift the pin value through both stages
    always_comb begin
        st_next = st_reg;
        st_next.s1 = d;
        st_next.s2 = st_reg.s1;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign q = st_reg.s2;
endmodule : cef_sync

// ### verif/cef_host_model.sv
// Purpose: Host side of the register port of the event logic
// Assumes: One access at a time, strobes launched just after a rising edge
// Notes: Read data is taken at the falling edge of the answer cycle
`timescale 1ns/1ps
module cef_host_model (
    // Clock and answer
    input wire logic clk,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid,
    // Request
    output logic reg_rd,
    output logic reg_wr,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata
);
    // Idle bus until the first access
    initial {reg_rd, reg_wr, reg_addr, reg_wdata} = 18'h0;
    // Single-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    // Read strobe; the answer stands one cycle only, so sample it mid-cycle
    task automatic rd(input logic [7:0] a, output logic [7:0] d,
                      output logic v);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        d = reg_rdata;
        v = reg_rvalid;
    endtask : rd
endmodule : cef_host_model

// ### verif/cef_event_logic_asserts.sv
// Purpose: Port-level checks of the event flag and mask logic
// Assumes: Status inputs change just after a rising edge
// Notes: Alert latency is two sync stages plus the compare stage
`timescale 1ns/1ps
module cef_event_checker (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Register port
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid,
    // Events and alert
    input wire logic power_good,
    input wire logic input_overvoltage,
    input wire logic host_alert
);
    import cef_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // One read of one address
    sequence s_read(logic [7:0] a);
        reg_rd && reg_addr == a;
    endsequence
    // Unimplemented bits answer zero
    property p_zero_bits(logic [7:0] a, logic [7:0] used);
        s_read(a) |=> reg_rvalid && (reg_rdata & ~used) == 8'h00;
    endproperty
    a_read_answer: assert property (reg_rd |=> reg_rvalid)
        else $error("read not answered next cycle");
    a_idle_data: assert property (!reg_rvalid |-> reg_rdata == 8'h00)
        else $error("read data not zero while idle");
    a_flags_a_zero: assert property (
        p_zero_bits(CEF_FLAGS_A_ADDR, CEF_FLAGS_A_USED))
        else $error("reserved bit set in flags a");
    a_flags_b_zero: assert property (
        p_zero_bits(CEF_FLAGS_B_ADDR, CEF_FLAGS_B_USED))
        else $error("reserved bit set in flags b");
    a_fault_zero: assert property (
        p_zero_bits(CEF_FAULT_ADDR, CEF_FAULT_USED))
        else $error("reserved bit set in fault flags");
    a_mask_zero: assert property (
        p_zero_bits(CEF_MASK_A_ADDR, CEF_MASK_A_USED))
        else $error("reserved bit set in mask");
    a_unmapped_zero: assert property (
        reg_rd && (reg_addr < 8'h0f || reg_addr > 8'h12)
        |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    // Unmaskable here, so every power good change and overvoltage rise must alert after the sync delay
    a_pgood_alert: assert property (
        $changed(power_good) |-> ##3 host_alert)
        else $error("power good toggle gave no alert");
    a_ovp_alert: assert property (
        $rose(input_overvoltage) |-> ##3 host_alert)
        else $error("overvoltage entry gave no alert");
endmodule : cef_event_checker
bind cef_event_logic cef_event_checker u_chk (.clk(clk), .rstn(rstn),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .power_good(power_good),
    .input_overvoltage(input_overvoltage), .host_alert(host_alert));

// ### verif/tb_charger_event_flag_mask_logic.sv
// Purpose: Self-checking bench for the event flag and mask logic
// Assumes: Status inputs change one at a time, at least six cycles apart
// Notes: Flags, mask and alert count are modelled in integers
`timescale 1ns/1ps
module tb_charger_event_flag_mask_logic;
    import cef_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic cmd = 1'b0;
    logic wdx = 1'b0;
    logic rate = 1'b0;
    logic [22:0] st = '0;
    logic reg_rd, reg_wr, reg_rvalid, host_alert, rd_v;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_d, w;
    int num_errors = 0;
    int compares = 0;
    int cycles = 0;
    int alerts = 0;
    int exp_alerts = 0;
    int msk = 0;
    int flg[3] = '{0, 0, 0};
    always #4 clk = ~clk;
    cef_host_model host (.clk(clk), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .reg_rd(reg_rd), .reg_wr(reg_wr),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata));
    cef_event_logic DUT (.clk(clk), .rstn(rstn), .reg_rd(reg_rd),
        .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_reset_cmd(cmd), .watchdog_expired(wdx), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .input_current_regulation(st[0]),
        .input_voltage_regulation(st[1]), .die_thermal_regulation(st[2]),
        .watchdog_expiry_status(st[3]), .charge_state_code(st[6:4]),
        .power_good(st[7]), .input_source_code(st[10:8]),
        .battery_temp_zone_code(st[13:11]),
        .current_optimizer_state(st[15:14]),
        .minimum_system_regulation(st[16]), .input_overvoltage(st[17]),
        .thermal_shutdown(st[18]), .battery_overvoltage(st[19]),
        .safety_timer_expired(st[20]), .reverse_output_fault(st[21]),
        .conversion_rate(rate), .conversion_done(st[22]),
        .host_alert(host_alert));
    // Count alert pulses; a hang ends the run as a failure
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (host_alert === 1'b1) alerts <= alerts + 1;
        if (cycles == 4000) begin
            num_errors = num_errors + 1;
            wrap_up();
        end
    end
    task automatic chk_reg(input string n, input logic [7:0] e,
                           input logic [7:0] s);
        compares++;
        if (s !== e) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask : chk_reg
    task automatic chk_cnt(input string n, input int e, input int s);
        compares++;
        if (s != e) begin
            num_errors++;
            $display("[ERR] %s expected %0d seen %0d", n, e, s);
        end
    endtask : chk_cnt
    task automatic read_chk(input logic [7:0] a, input logic [7:0] e);
        host.rd(a, rd_d, rd_v);
        chk_reg("rvalid", 8'h01, {7'h0, rd_v});
        chk_reg("rdata", e, rd_d);
    endtask : read_chk
    // Flag slot of input bit k, as register index times eight plus bit
    function automatic int tgt(input int k);
        if (k < 4) return 6 - k;
        if (k < 7) return 0;
        if (k < 8) return 15;
        if (k < 11) return 12;
        if (k < 14) return 10;
        if (k < 16) return 9;
        if (k < 17) return 8;
        if (k < 21) return 40 - k;
        return 16;
    endfunction : tgt
    // Flip one input; single-bit inputs other than toggles count on a rise
    task automatic step(input int k);
        int t;
        t = tgt(k);
        @(posedge clk);
        st[k] <= ~st[k];
        if (k == 22) begin
            if (!st[k] && rate && !msk[7]) exp_alerts++;
        end else if (!st[k] || (k > 3 && k < 17)) begin
            flg[t / 8] |= 1 << (t % 8);
            if (t > 7 || !msk[t]) exp_alerts++;
        end
        repeat (5) @(posedge clk);
    endtask : step
    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : wrap_up
    // Main sequence: reset values, then rounds of random events
    initial begin
        void'($urandom(10286));
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        host.wr(CEF_FLAGS_A_ADDR, 8'hff);
        for (int a = 15; a < 20; a++) read_chk(8'(a), 8'h00);
        for (int r = 0; r < 6; r++) begin
            w = 8'($urandom);
            rate <= 1'($urandom % 2);
            host.wr(CEF_MASK_A_ADDR, w);
            msk = w & CEF_MASK_A_USED;
            read_chk(CEF_MASK_A_ADDR, 8'(msk));
            repeat (12) step($urandom % 23);
            @(posedge clk);
            wdx <= 1'b1;
            cmd <= (r == 4);
            @(posedge clk);
            {wdx, cmd} <= 2'b00;
            if (r == 4) flg = '{0, 0, 0};
            if (r == 4) read_chk(CEF_MASK_A_ADDR, 8'h00);
            for (int i = 0; i < 3; i++) begin
                read_chk(CEF_FLAGS_A_ADDR + 8'(i), 8'(flg[i]));
                flg[i] = 0;
            end
            read_chk(CEF_FAULT_ADDR, 8'h00);
            chk_cnt("alerts", exp_alerts, alerts);
        end
        wrap_up();
    end
endmodule : tb_charger_event_flag_mask_logic
